// ### logic/ecc_read_response_status.sv
// Purpose: double-bit ECC error logging, interrupt and read response status
// Assumes: read completions arrive with their slot index and a detect flag
// Notes: Notes on behaviour below
// Notes on behaviour
// - a double-bit read error is logged in registers and raises the interrupt
// - a read with a double-bit error returns an error code with its data
// - response store has 32 entries, allocated round robin to reads
// - every entry reports its own status; no cross-slot status leakage
// - logging and interrupt flag every error, whichever slot carried it
// - error event is bit 4 of raw and masked status, reads 1 when set
// - error address captured in a readable 32-bit log field
// - bit 4 of the enable-set register enables error signalling
// - error-free reads answer okay; interrupt and log stay unchanged
//
// The placing of the registers and the AXI4-Lite interface to the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
module ecc_read_response_status
	import ecc_resp_pkg::*;
(
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// read completion from the memory side
	input wire logic rd_alloc,
	input wire logic rd_done,
	input wire logic [slot_w-1:0] rd_done_slot,
	input wire logic [31:0] rd_done_addr,
	input wire logic rd_dbl_err,
	input wire logic [31:0] rd_data,
	// response to requesting master
	output logic [slot_w-1:0] alloc_slot,
	output logic resp_valid,
	output logic [31:0] resp_data,
	output logic [1:0] resp_status,
	output logic [slot_w-1:0] resp_slot,
	output logic irq,
	// axi4-lite slave
	input wire logic [7:0] s_awaddr,
	input wire logic s_awvalid,
	output logic s_awready,
	input wire logic [31:0] s_wdata,
	input wire logic [3:0] s_wstrb,
	input wire logic s_wvalid,
	output logic s_wready,
	output logic [1:0] s_bresp,
	output logic s_bvalid,
	input wire logic s_bready,
	input wire logic [7:0] s_araddr,
	input wire logic s_arvalid,
	output logic s_arready,
	output logic [31:0] s_rdata,
	output logic [1:0] s_rresp,
	output logic s_rvalid,
	input wire logic s_rready
);

	////////////////////////////////////////////////////////////////////////
	// response status store, one flop per slot
	logic [fifo_depth-1:0] slot_err_r, slot_err_nxt;
	logic [slot_w-1:0] alloc_slot_r, alloc_slot_nxt;
	logic resp_valid_r, resp_valid_nxt;
	logic [31:0] resp_data_r, resp_data_nxt;
	logic [1:0] resp_status_r, resp_status_nxt;
	logic [slot_w-1:0] resp_slot_r, resp_slot_nxt;

	always_comb begin
		slot_err_nxt = slot_err_r;
		alloc_slot_nxt = alloc_slot_r;
		if (rd_alloc) begin
			alloc_slot_nxt = alloc_slot_r + 5'h01;
		end
		if (rd_done) begin
			// indexed by the completion's own slot, never a neighbour's
			slot_err_nxt[rd_done_slot] = rd_dbl_err;
		end
		resp_valid_nxt = rd_done;
		resp_data_nxt = rd_done ? rd_data : resp_data_r;
		resp_slot_nxt = rd_done ? rd_done_slot : resp_slot_r;
		resp_status_nxt = resp_status_r;
		if (rd_done) begin
			// status comes back out of the completion's own entry
			resp_status_nxt = slot_err_nxt[rd_done_slot] ? resp_slverr : resp_okay;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			slot_err_r <= '0;
			alloc_slot_r <= 5'h00;
			resp_valid_r <= 1'b0;
			resp_data_r <= 32'h00000000;
			resp_status_r <= resp_okay;
			resp_slot_r <= 5'h00;
		end else begin
			slot_err_r <= slot_err_nxt;
			alloc_slot_r <= alloc_slot_nxt;
			resp_valid_r <= resp_valid_nxt;
			resp_data_r <= resp_data_nxt;
			resp_status_r <= resp_status_nxt;
			resp_slot_r <= resp_slot_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// error record and interrupt
	logic raw_r, raw_nxt;
	logic en_r, en_nxt;
	logic irq_r, irq_nxt;
	logic [31:0] addr_log_r, addr_log_nxt;
	logic wr_go;
	logic [7:0] wr_addr;
	logic wr_bit;
	logic dbl_event;

	assign dbl_event = rd_done && rd_dbl_err;

	always_comb begin
		raw_nxt = raw_r;
		en_nxt = en_r;
		addr_log_nxt = addr_log_r;
		// write-one-to-clear on raw status; a new event wins over the clear
		if (wr_go && wr_bit) begin
			if (wr_addr == raw_status_off || wr_addr == masked_status_off) begin
				raw_nxt = 1'b0;
			end
			if (wr_addr == enable_set_off) begin
				en_nxt = 1'b1;
			end
			if (wr_addr == enable_clr_off) begin
				en_nxt = 1'b0;
			end
		end
		if (dbl_event) begin
			raw_nxt = 1'b1;
			addr_log_nxt = rd_done_addr;
		end
		irq_nxt = raw_nxt && en_nxt;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			raw_r <= 1'b0;
			en_r <= 1'b0;
			irq_r <= 1'b0;
			addr_log_r <= addr_log_reset;
		end else begin
			raw_r <= raw_nxt;
			en_r <= en_nxt;
			irq_r <= irq_nxt;
			addr_log_r <= addr_log_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// axi4-lite slave: address and data latched independently
	logic aw_held_r, aw_held_nxt;
	logic [7:0] aw_addr_r, aw_addr_nxt;
	logic w_held_r, w_held_nxt;
	logic [31:0] w_data_r, w_data_nxt;
	logic [3:0] w_strb_r, w_strb_nxt;
	logic bvalid_r, bvalid_nxt;
	logic [1:0] bresp_r, bresp_nxt;
	logic rvalid_r, rvalid_nxt;
	logic [31:0] rdata_r, rdata_nxt;
	logic [1:0] rresp_r, rresp_nxt;

	function automatic logic mapped(input logic [7:0] a);
		mapped = (a == raw_status_off) || (a == masked_status_off) ||
			(a == enable_set_off) || (a == enable_clr_off) || (a == error_addr_off);
	endfunction

	assign wr_go = aw_held_r && w_held_r && !bvalid_r;
	assign wr_addr = aw_addr_r;
	// the source may move its data lines once taken, so use the held copy
	assign wr_bit = w_strb_r[0] && w_data_r[dbl_err_bit];

	always_comb begin
		aw_held_nxt = aw_held_r;
		aw_addr_nxt = aw_addr_r;
		w_held_nxt = w_held_r;
		w_data_nxt = w_data_r;
		w_strb_nxt = w_strb_r;
		bvalid_nxt = bvalid_r;
		bresp_nxt = bresp_r;
		rvalid_nxt = rvalid_r;
		rdata_nxt = rdata_r;
		rresp_nxt = rresp_r;
		if (s_awvalid && !aw_held_r) begin
			aw_held_nxt = 1'b1;
			aw_addr_nxt = {s_awaddr[7:2], 2'h0};
		end
		if (s_wvalid && !w_held_r) begin
			w_held_nxt = 1'b1;
			w_data_nxt = s_wdata;
			w_strb_nxt = s_wstrb;
		end
		if (wr_go) begin
			aw_held_nxt = 1'b0;
			w_held_nxt = 1'b0;
			bvalid_nxt = 1'b1;
			bresp_nxt = mapped(aw_addr_r) ? resp_okay : resp_slverr;
		end
		if (bvalid_r && s_bready) begin
			bvalid_nxt = 1'b0;
		end
		if (s_arvalid && !rvalid_r) begin
			rvalid_nxt = 1'b1;
			rresp_nxt = mapped({s_araddr[7:2], 2'h0}) ? resp_okay : resp_slverr;
			rdata_nxt = 32'h00000000;
			unique case ({s_araddr[7:2], 2'h0})
				raw_status_off: rdata_nxt[dbl_err_bit] = raw_r;
				masked_status_off: rdata_nxt[dbl_err_bit] = raw_r && en_r;
				enable_set_off, enable_clr_off: rdata_nxt[dbl_err_bit] = en_r;
				error_addr_off: rdata_nxt = addr_log_r;
				default: rdata_nxt = 32'h00000000;
			endcase
		end else if (rvalid_r && s_rready) begin
			rvalid_nxt = 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_r <= 1'b0;
			aw_addr_r <= 8'h00;
			w_held_r <= 1'b0;
			w_data_r <= 32'h00000000;
			w_strb_r <= 4'h0;
			bvalid_r <= 1'b0;
			bresp_r <= resp_okay;
			rvalid_r <= 1'b0;
			rdata_r <= 32'h00000000;
			rresp_r <= resp_okay;
		end else begin
			aw_held_r <= aw_held_nxt;
			aw_addr_r <= aw_addr_nxt;
			w_held_r <= w_held_nxt;
			w_data_r <= w_data_nxt;
			w_strb_r <= w_strb_nxt;
			bvalid_r <= bvalid_nxt;
			bresp_r <= bresp_nxt;
			rvalid_r <= rvalid_nxt;
			rdata_r <= rdata_nxt;
			rresp_r <= rresp_nxt;
		end
	end

	// ready asserted only while the holding flop is empty, so a source never loses an item
	assign s_awready = !aw_held_r;
	assign s_wready = !w_held_r;
	assign s_bvalid = bvalid_r;
	assign s_bresp = bresp_r;
	assign s_arready = !rvalid_r;
	assign s_rvalid = rvalid_r;
	assign s_rdata = rdata_r;
	assign s_rresp = rresp_r;
	assign alloc_slot = alloc_slot_r;
	assign resp_valid = resp_valid_r;
	assign resp_data = resp_data_r;
	assign resp_status = resp_status_r;
	assign resp_slot = resp_slot_r;
	assign irq = irq_r;

	////////////////////////////////////////////////////////////////////////
	// checks
	resp_err_a: assert property (@(posedge aclk) disable iff (!aresetn)
		rd_done && rd_dbl_err |=> resp_valid && resp_status == resp_slverr)
		else $error("errored read not flagged");
	resp_ok_a: assert property (@(posedge aclk) disable iff (!aresetn)
		rd_done && !rd_dbl_err |=> resp_status == resp_okay)
		else $error("clean read flagged");
	own_slot_a: assert property (@(posedge aclk) disable iff (!aresetn)
		rd_done |=> slot_err_r[$past(rd_done_slot)] == $past(rd_dbl_err))
		else $error("slot status from wrong entry");
	raw_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
		dbl_event |=> raw_r)
		else $error("raw flag missed event");
	addr_log_a: assert property (@(posedge aclk) disable iff (!aresetn)
		dbl_event |=> addr_log_r == $past(rd_done_addr))
		else $error("error address not logged");
	log_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
		!dbl_event |=> $stable(addr_log_r))
		else $error("address log moved without error");
	irq_gate_a: assert property (@(posedge aclk) disable iff (!aresetn)
		!en_r && !(wr_go && wr_addr == enable_set_off) |=> !irq)
		else $error("interrupt not gated by enable");
	slot_rr_a: assert property (@(posedge aclk) disable iff (!aresetn)
		rd_alloc |=> alloc_slot == $past(alloc_slot) + 5'h01)
		else $error("slot allocation not round robin");
	irq_any_a: assert property (@(posedge aclk) disable iff (!aresetn)
		dbl_event && en_r && !(wr_go && wr_addr == enable_clr_off) |=> irq)
		else $error("interrupt missed for slot");
	raw_free_a: assert property (@(posedge aclk) disable iff (!aresetn)
		dbl_event && !en_r && !(wr_go && wr_addr == enable_set_off) |=> raw_r && !irq)
		else $error("raw flag tied to enable");
	quiet_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
		!dbl_event && !raw_r |=> !raw_r && !irq)
		else $error("flag set without error");
	en_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
		wr_go && wr_addr == enable_set_off && wr_bit |=> en_r)
		else $error("enable set write lost");
endmodule
`default_nettype wire

// ### logic/ecc_resp_pkg.sv
// Purpose: constants for the double-bit error reporting path
// Assumes: 32-bit AXI4-Lite register bus, byte addresses
// Notes: offsets are word aligned
package ecc_resp_pkg;
	localparam logic [7:0] raw_status_off = 8'h00;
	localparam logic [7:0] masked_status_off = 8'h04;
	localparam logic [7:0] enable_set_off = 8'h08;
	localparam logic [7:0] enable_clr_off = 8'h0c;
	localparam logic [7:0] error_addr_off = 8'h10;
	localparam int dbl_err_bit = 4;
	localparam int fifo_depth = 32;
	localparam int slot_w = 5;
	localparam logic [1:0] resp_okay = 2'h0;
	localparam logic [1:0] resp_slverr = 2'h2;
	localparam logic [31:0] addr_log_reset = 32'h00000000;
endpackage

// ### bench/read_master_model.sv
// Purpose: requesting master that issues reads and samples their status
// Assumes: the response stands one cycle after the completion is taken
// Notes: released lines show the inverse of their last value
`timescale 1ns/1ps
`default_nettype none
module read_master_model
	import ecc_resp_pkg::*;
(
	// clock
	input wire logic aclk,
	// request side
	output logic rd_alloc,
	output logic rd_done,
	output logic [slot_w-1:0] rd_done_slot,
	output logic [31:0] rd_done_addr,
	output logic rd_dbl_err,
	output logic [31:0] rd_data,
	// response side
	input wire logic [slot_w-1:0] alloc_slot,
	input wire logic resp_valid,
	input wire logic [31:0] resp_data,
	input wire logic [1:0] resp_status,
	input wire logic [slot_w-1:0] resp_slot
);
	logic [1:0] got_status = 2'h0;
	logic [slot_w-1:0] got_slot = '0;
	logic data_ok = 1'b0;
	initial begin
		rd_alloc = 1'b0;
		rd_done = 1'b0;
		rd_done_slot = '0;
		rd_done_addr = 32'h00000000;
		rd_dbl_err = 1'b0;
		rd_data = 32'h00000000;
	end
	task automatic read(input logic err, input logic [31:0] addr);
		logic [slot_w-1:0] slot;
		@(posedge aclk);
		slot = alloc_slot;
		rd_alloc <= 1'b1;
		@(posedge aclk);
		rd_alloc <= 1'b0;
		rd_done <= 1'b1;
		rd_done_slot <= slot;
		rd_done_addr <= addr;
		rd_dbl_err <= err;
		rd_data <= ~addr;
		@(posedge aclk);
		// flip stale lines so an old value cannot pass for a fresh one
		rd_done <= 1'b0;
		rd_done_slot <= ~slot;
		rd_done_addr <= ~addr;
		rd_dbl_err <= ~err;
		rd_data <= addr;
		@(posedge aclk);
		got_status = resp_status;
		got_slot = resp_slot;
		// data is taken only with a good status in the same response
		data_ok = resp_valid && resp_status === resp_okay && resp_data === ~addr;
	endtask
endmodule
`default_nettype wire

// ### bench/test_ecc_read_response_status.sv
// Purpose: register and response checks of the double-bit error path
// Assumes: axi4-lite master tasks, one access at a time
// Notes: passes of 32 reads keep slot index equal to loop index
`timescale 1ns/1ps
`default_nettype none
module test_ecc_read_response_status;
	import ecc_resp_pkg::*;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] s_awaddr = 8'h00, s_araddr = 8'h00;
	logic [31:0] s_wdata = 32'h00000000, s_rdata, rd_done_addr, rd_data, resp_data, last_err, v;
	logic [3:0] s_wstrb = 4'h0;
	logic s_awvalid = 1'b0, s_wvalid = 1'b0, s_bready = 1'b0, s_arvalid = 1'b0, s_rready = 1'b0;
	logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid, irq, resp_valid;
	logic rd_alloc, rd_done, rd_dbl_err;
	logic [1:0] s_bresp, s_rresp, resp_status, r;
	logic [slot_w-1:0] alloc_slot, rd_done_slot, resp_slot;
	int fail_count = 0, total_checks = 0, nreads = 0;
	localparam logic [31:0] bit_m = 32'h00000010;
	initial begin
		forever #25 aclk = ~aclk;
	end
	ecc_read_response_status u_ecc_read_response_status (.aclk(aclk), .aresetn(aresetn),
		.rd_alloc(rd_alloc), .rd_done(rd_done), .rd_done_slot(rd_done_slot),
		.rd_done_addr(rd_done_addr), .rd_dbl_err(rd_dbl_err), .rd_data(rd_data),
		.alloc_slot(alloc_slot), .resp_valid(resp_valid), .resp_data(resp_data),
		.resp_status(resp_status), .resp_slot(resp_slot), .irq(irq),
		.s_awaddr(s_awaddr), .s_awvalid(s_awvalid), .s_awready(s_awready),
		.s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid), .s_wready(s_wready),
		.s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready),
		.s_araddr(s_araddr), .s_arvalid(s_arvalid), .s_arready(s_arready),
		.s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready));
	read_master_model u_read_master_model (.aclk(aclk), .rd_alloc(rd_alloc),
		.rd_done(rd_done), .rd_done_slot(rd_done_slot), .rd_done_addr(rd_done_addr),
		.rd_dbl_err(rd_dbl_err), .rd_data(rd_data), .alloc_slot(alloc_slot),
		.resp_valid(resp_valid), .resp_data(resp_data), .resp_status(resp_status),
		.resp_slot(resp_slot));
	////////////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("wrong value at %0t: got %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	// no cycle count is assumed; only the watchdog ends a wait
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] rsp);
		@(posedge aclk);
		s_awaddr <= a;
		s_wdata <= d;
		s_wstrb <= 4'hf;
		s_awvalid <= 1'b1;
		s_wvalid <= 1'b1;
		s_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_awready) s_awvalid <= 1'b0;
			if (s_wready) s_wvalid <= 1'b0;
		end while (!s_bvalid);
		rsp = s_bresp;
		s_bready <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rsp);
		@(posedge aclk);
		s_araddr <= a;
		s_arvalid <= 1'b1;
		s_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_arready) s_arvalid <= 1'b0;
		end while (!s_rvalid);
		d = s_rdata;
		rsp = s_rresp;
		s_rready <= 1'b0;
	endtask
	task automatic run_pass(input int err_idx);
		for (int i = 0; i < 32; i++) begin
			v = 32'h00010000 | (nreads << 2);
			if (i == err_idx) last_err = v;
			u_read_master_model.read(i == err_idx, v);
			check(u_read_master_model.got_slot, nreads % 32);
			check(u_read_master_model.got_status, i == err_idx ? resp_slverr : resp_okay);
			check(u_read_master_model.data_ok, i != err_idx);
			nreads++;
		end
	endtask
	// one test step: read a register and compare its value
	task automatic expect_reg(input logic [7:0] a, input logic [31:0] exp);
		rd(a, v, r);
		check(v, exp);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		expect_reg(raw_status_off, 32'h00000000);
		expect_reg(error_addr_off, addr_log_reset);
		expect_reg(8'h20, 32'h00000000);
		check(r, resp_slverr);
		wr(8'h24, bit_m, r);
		check(r, resp_slverr);
		$display("test reset and unmapped done");
		run_pass(20);
		expect_reg(raw_status_off, bit_m);
		expect_reg(masked_status_off, 32'h00000000);
		check(irq, 1'b0);
		expect_reg(error_addr_off, last_err);
		$display("test slot 20 error done");
		wr(raw_status_off, bit_m, r);
		expect_reg(raw_status_off, 32'h00000000);
		wr(enable_set_off, bit_m, r);
		expect_reg(enable_set_off, bit_m);
		run_pass(21);
		expect_reg(masked_status_off, bit_m);
		check(irq, 1'b1);
		expect_reg(error_addr_off, last_err);
		$display("test slot 21 error done");
		wr(masked_status_off, bit_m, r);
		expect_reg(raw_status_off, 32'h00000000);
		check(irq, 1'b0);
		wr(enable_clr_off, bit_m, r);
		run_pass(32);
		expect_reg(raw_status_off, 32'h00000000);
		check(irq, 1'b0);
		expect_reg(error_addr_off, last_err);
		$display("test clean pass done");
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		expect_reg(error_addr_off, addr_log_reset);
		expect_reg(enable_set_off, 32'h00000000);
		check(irq, 1'b0);
		$display("test second reset done");
		conclude();
	end
	initial begin
		repeat (20000) @(posedge aclk);
		fail_count++;
		conclude();
	end
endmodule
`default_nettype wire
